//--- inc/wdg_pkg.sv
/*
  Shared constants and carrier types for the guard timer and reset block.
  Assumes a single 200 MHz core clock and an APB register port.
*/
`default_nettype none
package wdg_pkg;

  // Clock and oscillator rates
  localparam int CLK_MHZ = 200;
  localparam int CLK_HZ  = 200_000_000;
  localparam int OSC_HZ  = 128_000;
  // Slow tick is an enable pulse; 1562.5 rounds down, tick runs a bit fast
  localparam int OSC_DIV = CLK_HZ / OSC_HZ;

  // Timing figures and derived cycle counts (least times round up)
  localparam int MIN_DROP_NS     = 2000;
  localparam int MIN_DROP_CYCLES = (MIN_DROP_NS * CLK_MHZ + 999) / 1000;
  localparam int STARTUP_NS      = 4_100_000;
  localparam int STARTUP_CYCLES  = (STARTUP_NS * CLK_MHZ + 999) / 1000;
  localparam int UNLOCK_CYCLES   = 4;
  localparam int BASE_TICKS      = 2048;
  localparam logic [3:0] SEL_MAX = 4'h9;

  // Register byte offsets
  localparam logic [11:0] OFS_CTRL    = 12'h000;
  localparam logic [11:0] OFS_CAUSE   = 12'h004;
  localparam logic [11:0] OFS_AUX     = 12'h008;
  localparam logic [11:0] OFS_RESTART = 12'h00c;

  // Control register fields
  localparam int CTRL_FLAG   = 7;
  localparam int CTRL_IRQ_EN = 6;
  localparam int CTRL_SEL3   = 5;
  localparam int CTRL_UNLOCK = 4;
  localparam int CTRL_RST_EN = 3;
  // Cause and auxiliary register fields
  localparam int CAUSE_GUARD = 3;
  localparam int CAUSE_DROP  = 2;
  localparam int AUX_BANDGAP = 0;
  localparam int AUX_CONV    = 1;

  // Reset values
  localparam logic [3:0] SEL_RESET    = 4'h0;
  localparam logic [2:0] UNLOCK_RESET = 3'h0;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } wdg_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } wdg_apb_rsp_t;

endpackage
`default_nettype wire

//--- hw/wdg_tick_div.sv
/*
  Divider making the 128 kHz guard oscillator tick as a one-cycle enable.
  Assumes core_clk at the package rate.
*/
`timescale 1ns/1ps
`default_nettype none
module wdg_tick_div (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic arst_n,
  // Tick out
  output var  logic tick
);

  typedef struct packed {
    logic [10:0] cnt;
    logic        tick;
  } wdg_div_state_t;

  localparam logic [10:0] DIV_LAST = 11'(wdg_pkg::OSC_DIV - 1);

  wdg_div_state_t s;
  wdg_div_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.cnt == DIV_LAST) begin
      next_s.cnt = 11'h000;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 11'h001;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  tick_single_a: assert property (tick |=> !tick)
    else $error("guard tick longer than one cycle");

endmodule
`default_nettype wire

//--- hw/wdg_reset_seq.sv
/*
  Supply drop filter and start-up delay counter driving the system reset.
  Assumes the drop comparator output is asynchronous to core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module wdg_reset_seq #(
  parameter int STARTUP_DELAY_CYCLES = wdg_pkg::STARTUP_CYCLES
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic arst_n,
  // Supply monitor
  input  wire logic monitored_supply_low,
  input  wire logic detect_en,
  // Guard timer reset pulse
  input  wire logic guard_pulse,
  // Results
  output var  logic drop_event,
  output var  logic system_reset
);

  typedef struct packed {
    logic        s1;
    logic        s2;
    logic [8:0]  drop_cnt;
    logic        in_drop;
    logic        pulse_d;
    logic        delay_run;
    logic [29:0] delay_cnt;
    logic        drop_event;
    logic        rst_out;
  } wdg_seq_state_t;

  localparam logic [8:0]  DROP_MIN = 9'(wdg_pkg::MIN_DROP_CYCLES);
  localparam logic [29:0] DELAY_LAST = 30'(STARTUP_DELAY_CYCLES - 1);

  wdg_seq_state_t s;
  wdg_seq_state_t next_s;
  logic           low_now;
  logic           qualify;

  always_comb begin
    next_s = s;
    next_s.s1 = monitored_supply_low;
    next_s.s2 = s.s1;
    next_s.drop_event = 1'b0;
    next_s.pulse_d = guard_pulse;
    low_now = s.s2 && detect_en;
    qualify = 1'b0;
    if (low_now) begin
      if (s.drop_cnt != DROP_MIN) begin
        next_s.drop_cnt = s.drop_cnt + 9'h001;
      end
      qualify = (s.drop_cnt == DROP_MIN) && !s.in_drop;
    end else begin
      next_s.drop_cnt = 9'h000;
    end
    if (qualify) begin
      next_s.in_drop = 1'b1;
      next_s.drop_event = 1'b1;
      next_s.delay_run = 1'b0;
    end else if (s.in_drop && !low_now) begin
      next_s.in_drop = 1'b0;
      next_s.delay_run = 1'b1;
      next_s.delay_cnt = 30'h0;
    end
    if (s.pulse_d && !guard_pulse && !next_s.in_drop) begin
      next_s.delay_run = 1'b1;
      next_s.delay_cnt = 30'h0;
    end else if (s.delay_run && !qualify) begin
      if (s.delay_cnt == DELAY_LAST) begin
        next_s.delay_run = 1'b0;
      end else begin
        next_s.delay_cnt = s.delay_cnt + 30'h1;
      end
    end
    next_s.rst_out = next_s.in_drop || next_s.delay_run || guard_pulse;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign drop_event = s.drop_event;
  assign system_reset = s.rst_out;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  drop_reset_a: assert property (qualify |=> system_reset)
    else $error("drop did not raise reset at once");
  short_drop_a: assert property (!low_now |=> !s.in_drop)
    else $error("drop state without a low supply");
  delay_hold_a: assert property (s.delay_run |-> system_reset)
    else $error("reset released during start-up delay");
  pulse_fall_a: assert property (
    $fell(guard_pulse) && !s.in_drop |=> s.delay_run)
    else $error("delay did not start on pulse fall");
  drop_seen_c: cover property (qualify);
  release_seen_c: cover property ($fell(system_reset));

endmodule
`default_nettype wire

//--- hw/wdg_guard_top.sv
/*
  Guard timer with interrupt and reset modes, timed change sequence,
  reset cause flags and bandgap enable, reached over APB.
  Assumes fuse and supply inputs are asynchronous pins and that the
  vector acknowledge comes from core logic on core_clk.
*/
// Overview of operation
// - Qualified supply drop asserts reset immediately
// - Reset held through start-up delay after recovery
// - Drops shorter than minimum duration ignored
// - Guard reset pulse lasts one clock
// - Start-up delay begins at pulse fall
// - Reference on if fuse, bandgap or converter
// - Guard counter advances on 128 kHz ticks
// - Expiry gives interrupt, reset or both
// - Interrupt mode raises wake-capable interrupt only
// - Reset mode expiry resets the system
// - Combined mode: interrupt first, then reset
// - Always-on fuse forces reset mode
// - Disable or select change only via sequence
// - Change write accepted within four cycles only
// - Time-out selectable from 16ms to 8s
// - Guard stays enabled after guard reset
// - Enable reads set while reset flag set
// - Unlock bit clears itself after four cycles
// - Flag set on expiry, cleared by vector/one
// - Select codes map 2k doubling to 1024k
`timescale 1ns/1ps
`default_nettype none
module wdg_guard_top #(
  parameter int GUARD_BASE_TICKS     = wdg_pkg::BASE_TICKS,
  parameter int STARTUP_DELAY_CYCLES = wdg_pkg::STARTUP_CYCLES
) (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  arst_n,
  // APB slave
  input  wire wdg_pkg::wdg_apb_req_t apb_req,
  output var  wdg_pkg::wdg_apb_rsp_t apb_rsp,
  // Fuses and supply monitor pins
  input  wire logic                  guard_always_on_fuse,
  input  wire logic                  drop_detect_fuse,
  input  wire logic                  monitored_supply_low,
  // Core side
  input  wire logic                  irq_vector_ack,
  output var  logic                  guard_irq,
  output var  logic                  guard_reset_pulse,
  output var  logic                  system_reset,
  output var  logic                  reference_enable
);

  typedef struct packed {
    logic [1:0]  fuse_s1;
    logic [1:0]  fuse_s2;
    logic        irq_flag;
    logic        irq_en;
    logic        rst_en;
    logic [3:0]  sel;
    logic [2:0]  unlock_cnt;
    logic [20:0] count;
    logic        guard_flag;
    logic        drop_flag;
    logic        bandgap_sel;
    logic        conv_en;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        irq_out;
    logic        ref_en;
    logic        rst_pulse;
  } wdg_top_state_t;

  localparam logic [2:0] UNLOCK_LOAD = 3'(wdg_pkg::UNLOCK_CYCLES);

  wdg_top_state_t s;
  wdg_top_state_t next_s;

  logic        tick;
  logic        drop_event;
  logic        seq_reset;
  logic        fuse_on;
  logic        eff_rst_en;
  logic        eff_irq_en;
  logic        win;
  logic        setup;
  logic        wr;
  logic        wr_ctrl;
  logic        open_wr;
  logic        restart_wr;
  logic        running;
  logic        expire;
  logic [3:0]  sel_eff;
  logic [31:0] limit;
  logic [7:0]  wb;
  logic [7:0]  ctrl_rd;

  //////////////////////////////////////////////////////////////////////////

  wdg_tick_div u_tick (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .tick     (tick)
  );

  wdg_reset_seq #(
    .STARTUP_DELAY_CYCLES (STARTUP_DELAY_CYCLES)
  ) u_seq (
    .core_clk             (core_clk),
    .arst_n               (arst_n),
    .monitored_supply_low (monitored_supply_low),
    .detect_en            (s.fuse_s2[1]),
    .guard_pulse          (s.rst_pulse),
    .drop_event           (drop_event),
    .system_reset         (seq_reset)
  );

  //////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_s = s;
    next_s.fuse_s1 = {drop_detect_fuse, guard_always_on_fuse};
    next_s.fuse_s2 = s.fuse_s1;
    fuse_on = s.fuse_s2[0];
    eff_rst_en = s.rst_en || fuse_on || s.guard_flag;
    eff_irq_en = s.irq_en && !fuse_on;
    win = (s.unlock_cnt != 3'h0);
    ctrl_rd = {s.irq_flag, eff_irq_en, s.sel[3], win, eff_rst_en,
               s.sel[2:0]};
    setup = apb_req.psel && !apb_req.penable;
    wr = apb_req.psel && apb_req.penable && s.pready && apb_req.pwrite
         && !s.pslverr;
    wb = apb_req.pwdata[7:0];
    wr_ctrl = wr && (apb_req.paddr == wdg_pkg::OFS_CTRL);
    open_wr = wr_ctrl && wb[wdg_pkg::CTRL_UNLOCK]
              && wb[wdg_pkg::CTRL_RST_EN];
    restart_wr = wr && (apb_req.paddr == wdg_pkg::OFS_RESTART);

    // Zero-wait slave: data is captured in setup, ready in access
    next_s.pready = setup;
    next_s.pslverr = 1'b0;
    if (setup) begin
      next_s.prdata = 32'h0;
      unique case (apb_req.paddr)
        wdg_pkg::OFS_CTRL:    next_s.prdata = {24'h0, ctrl_rd};
        wdg_pkg::OFS_CAUSE:   next_s.prdata = {28'h0, s.guard_flag,
                                               s.drop_flag, 2'h0};
        wdg_pkg::OFS_AUX:     next_s.prdata = {30'h0, s.conv_en,
                                               s.bandgap_sel};
        wdg_pkg::OFS_RESTART: next_s.prdata = 32'h0;
        default:              next_s.pslverr = 1'b1;
      endcase
    end

    if (win) begin
      next_s.unlock_cnt = s.unlock_cnt - 3'h1;
    end
    if (wr_ctrl) begin
      next_s.irq_en = wb[wdg_pkg::CTRL_IRQ_EN];
      if (wb[wdg_pkg::CTRL_FLAG]) begin
        next_s.irq_flag = 1'b0;
      end
      // disable and select only inside window
      if (win && !wb[wdg_pkg::CTRL_UNLOCK]) begin
        next_s.rst_en = wb[wdg_pkg::CTRL_RST_EN];
        next_s.sel = {wb[wdg_pkg::CTRL_SEL3], wb[2:0]};
        next_s.unlock_cnt = 3'h0;
      end else if (wb[wdg_pkg::CTRL_RST_EN]) begin
        next_s.rst_en = 1'b1;
      end
      if (open_wr) begin
        next_s.unlock_cnt = UNLOCK_LOAD;
      end
    end
    if (wr && (apb_req.paddr == wdg_pkg::OFS_CAUSE)) begin
      if (!wb[wdg_pkg::CAUSE_GUARD]) begin
        next_s.guard_flag = 1'b0;
      end
      if (!wb[wdg_pkg::CAUSE_DROP]) begin
        next_s.drop_flag = 1'b0;
      end
    end
    if (wr && (apb_req.paddr == wdg_pkg::OFS_AUX)) begin
      next_s.bandgap_sel = wb[wdg_pkg::AUX_BANDGAP];
      next_s.conv_en = wb[wdg_pkg::AUX_CONV];
    end

    // codes above nine clamp to the longest
    sel_eff = (s.sel > wdg_pkg::SEL_MAX) ? wdg_pkg::SEL_MAX : s.sel;
    // base count doubled per select step
    limit = 32'(GUARD_BASE_TICKS) << sel_eff;
    running = eff_rst_en || eff_irq_en;
    expire = 1'b0;
    if (running && tick) begin
      if ({11'h0, s.count} >= (limit - 32'h1)) begin
        expire = 1'b1;
        next_s.count = 21'h0;
      end else begin
        next_s.count = s.count + 21'h1;
      end
    end
    if (restart_wr || !running) begin
      next_s.count = 21'h0;
    end

    // vector clears flag, combined mode drops enable
    if (irq_vector_ack) begin
      next_s.irq_flag = 1'b0;
      if (eff_rst_en && eff_irq_en) begin
        next_s.irq_en = 1'b0;
      end
    end
    if (expire && eff_irq_en && (!eff_rst_en || !s.irq_flag)) begin
      next_s.irq_flag = 1'b1;
    end
    next_s.rst_pulse = expire && eff_rst_en && (!eff_irq_en || s.irq_flag);

    // guard reset keeps guard enabled through flag
    if (s.rst_pulse || drop_event) begin
      next_s.irq_flag = 1'b0;
      next_s.irq_en = 1'b0;
      next_s.rst_en = 1'b0;
      next_s.sel = wdg_pkg::SEL_RESET;
      next_s.unlock_cnt = wdg_pkg::UNLOCK_RESET;
      next_s.count = 21'h0;
      next_s.bandgap_sel = 1'b0;
      next_s.conv_en = 1'b0;
    end
    if (s.rst_pulse) begin
      next_s.guard_flag = 1'b1;
    end
    if (drop_event) begin
      next_s.drop_flag = 1'b1;
    end

    // interrupt line doubles as wake request
    next_s.irq_out = next_s.irq_flag && next_s.irq_en && !fuse_on;
    // reference enable is an OR of three
    next_s.ref_en = s.fuse_s2[1] || s.bandgap_sel || s.conv_en;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign apb_rsp = '{pready: s.pready, pslverr: s.pslverr,
                     prdata: s.prdata};
  assign guard_irq = s.irq_out;
  assign guard_reset_pulse = s.rst_pulse;
  assign system_reset = seq_reset;
  assign reference_enable = s.ref_en;

  //////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  pulse_width_a: assert property (s.rst_pulse |=> !s.rst_pulse)
    else $error("guard reset pulse longer than one cycle");
  reset_mode_a: assert property (
    expire && eff_rst_en && !eff_irq_en |=> s.rst_pulse)
    else $error("reset mode expiry gave no pulse");
  irq_mode_a: assert property (
    expire && eff_irq_en && !eff_rst_en && !irq_vector_ack
    |=> s.irq_flag && !s.rst_pulse)
    else $error("interrupt mode expiry wrong action");
  combined_first_a: assert property (
    expire && eff_irq_en && eff_rst_en && !s.irq_flag
    |=> s.irq_flag && !s.rst_pulse)
    else $error("combined mode first expiry wrong");
  fuse_forced_a: assert property (
    fuse_on |-> eff_rst_en && !next_s.irq_out)
    else $error("always-on fuse did not force reset mode");
  select_locked_a: assert property (
    wr_ctrl && !win && !s.rst_pulse && !drop_event
    |=> $stable(s.sel))
    else $error("select changed outside the window");
  unlock_load_a: assert property (
    open_wr && !s.rst_pulse && !drop_event
    |=> s.unlock_cnt == UNLOCK_LOAD)
    else $error("unlock window not loaded");
  unlock_count_a: assert property (
    win && !wr_ctrl && !s.rst_pulse && !drop_event
    |=> s.unlock_cnt == $past(s.unlock_cnt) - 3'h1)
    else $error("unlock window did not count down");
  restart_clear_a: assert property (
    restart_wr |=> s.count == 21'h0)
    else $error("restart did not clear counter");
  flag_enable_a: assert property (
    setup && apb_req.paddr == wdg_pkg::OFS_CTRL && s.guard_flag
    |=> s.prdata[wdg_pkg::CTRL_RST_EN])
    else $error("enable read clear while reset flag set");
  stays_on_a: assert property (
    s.rst_pulse |=> s.guard_flag ##1 s.guard_flag)
    else $error("guard not enabled after guard reset");
  ref_or_a: assert property (
    ##2 s.ref_en == $past(s.fuse_s2[1] || s.bandgap_sel || s.conv_en))
    else $error("reference enable mismatch");
  tick_only_a: assert property (
    !tick && !restart_wr && !s.rst_pulse && !drop_event && running
    |=> $stable(s.count))
    else $error("counter moved without a tick");

  combined_reset_c: cover property (
    s.irq_flag && eff_irq_en && eff_rst_en ##[1:1000] s.rst_pulse);
  change_seq_c: cover property (open_wr ##[1:4] (wr_ctrl && win));
  irq_ack_c: cover property (s.irq_flag ##1 irq_vector_ack);

endmodule
`default_nettype wire

//--- test/wdg_core_model.sv
/*
  Core-side model: APB master for register access, restart writes,
  timed change sequence and vector acknowledge.
  Assumes core_clk from the bench and the slave's one access cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module wdg_core_model (
  // Clock
  input  wire logic                  core_clk,
  // APB master side
  output var  wdg_pkg::wdg_apb_req_t apb_req,
  input  wire wdg_pkg::wdg_apb_rsp_t apb_rsp,
  // Vector acknowledge
  output var  logic                  irq_vector_ack
);
  // Reference settle time before trusting comparator or converter
  localparam int REF_SETTLE_CYCLES = 16;
  logic [31:0] rd;
  logic        err;

  initial begin
    apb_req        = '0;
    irq_vector_ack = 1'h0;
  end

  //////////////////////////////////////////////////////////////////////////
  // Released fields are inverted so stale values never look valid
  // Waits for pready with no cycle limit; the bench watchdog ends a hang
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge core_clk);
    apb_req.psel    <= 1'h1;
    apb_req.penable <= 1'h0;
    apb_req.pwrite  <= w;
    apb_req.paddr   <= a;
    apb_req.pwdata  <= d;
    @(posedge core_clk);
    apb_req.penable <= 1'h1;
    @(posedge core_clk);
    while (apb_rsp.pready !== 1'h1) begin
      @(posedge core_clk);
    end
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel    <= 1'h0;
    apb_req.penable <= 1'h0;
    apb_req.paddr   <= ~a;
    apb_req.pwdata  <= ~d;
  endtask

  task automatic restart;
    xfer(1'h1, wdg_pkg::OFS_RESTART, 32'h0);
  endtask

  task automatic open_win;
    restart();
    xfer(1'h1, wdg_pkg::OFS_CTRL, 32'h18);
  endtask

  task automatic change(input logic [7:0] d);
    xfer(1'h1, wdg_pkg::OFS_CTRL, {24'h0, d & 8'hef});
  endtask

  task automatic init_clear;
    xfer(1'h1, wdg_pkg::OFS_CAUSE, 32'h0);
    open_win();
    change(8'h00);
  endtask

  task automatic settle;
    repeat (REF_SETTLE_CYCLES) @(posedge core_clk);
  endtask

  task automatic ack_vec;
    @(posedge core_clk);
    irq_vector_ack <= 1'h1;
    @(posedge core_clk);
    irq_vector_ack <= 1'h0;
  endtask
endmodule
`default_nettype wire

//--- test/wdg_guard_top_bench.sv
/*
  Self-checking bench: register table, then sequence, expiry, drop and
  reset cases. Assumes the core model as APB master.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("Error at %0t: got %h want %h", $time, (g), (e)); end end
module wdg_guard_top_bench;
  localparam int T = wdg_pkg::OSC_DIV;
  // Short base count and start-up delay keep the run small
  localparam int BASE  = 4;
  localparam int DELAY = 20;
  localparam logic [11:0] C = wdg_pkg::OFS_CTRL;
  localparam logic [11:0] R = wdg_pkg::OFS_CAUSE;
  typedef struct {
    logic        w;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] q;
    logic        e;
    logic        r;
  } wdg_row_t;
  wdg_row_t rows [10] = '{
    '{1'h0, 12'h000, 32'h0, 32'h0, 1'h0, 1'h0},
    '{1'h0, 12'h004, 32'h0, 32'h0, 1'h0, 1'h0},
    '{1'h0, 12'h008, 32'h0, 32'h0, 1'h0, 1'h0},
    '{1'h1, 12'h008, 32'h1, 32'h0, 1'h0, 1'h1},
    '{1'h0, 12'h008, 32'h0, 32'h1, 1'h0, 1'h1},
    '{1'h1, 12'h008, 32'h2, 32'h0, 1'h0, 1'h1},
    '{1'h0, 12'h008, 32'h0, 32'h2, 1'h0, 1'h1},
    '{1'h1, 12'h008, 32'h0, 32'h0, 1'h0, 1'h0},
    '{1'h0, 12'h010, 32'h0, 32'h0, 1'h1, 1'h0},
    '{1'h1, 12'h01c, 32'h5, 32'h0, 1'h1, 1'h0}};
  logic                  core_clk;
  logic                  arst_n;
  logic                  fuse_on;
  logic                  fuse_drop;
  logic                  sup_low;
  logic                  irq;
  logic                  pulse;
  logic                  srst;
  logic                  ref_en;
  logic                  ack;
  wdg_pkg::wdg_apb_req_t req;
  wdg_pkg::wdg_apb_rsp_t rsp;
  int                    fail_count = 0;
  int                    checks = 0;
  int                    pulses = 0;
  int                    n;
  int                    k;

  wdg_guard_top #(.GUARD_BASE_TICKS(BASE),
    .STARTUP_DELAY_CYCLES(DELAY)) DUT (
    .core_clk(core_clk), .arst_n(arst_n), .apb_req(req), .apb_rsp(rsp),
    .guard_always_on_fuse(fuse_on), .drop_detect_fuse(fuse_drop),
    .monitored_supply_low(sup_low), .irq_vector_ack(ack),
    .guard_irq(irq), .guard_reset_pulse(pulse), .system_reset(srst),
    .reference_enable(ref_en));
  wdg_core_model core (.core_clk(core_clk), .apb_req(req), .apb_rsp(rsp),
    .irq_vector_ack(ack));

  initial begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (pulse === 1'h1) pulses++;

  //////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    if (fail_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] q);
    core.xfer(1'h0, a, 32'h0);
    `CHK(core.rd, q)
  endtask

  // Bounded wait for an expiry, counting edges
  task automatic wait_ev(input bit want_pulse, output int c);
    c = 0;
    while ((want_pulse ? pulse : irq) !== 1'h1 && c < 20000) begin
      @(posedge core_clk);
      c++;
    end
    `CHK(c < 20000, 1'h1)
  endtask

  task automatic hold_len(output int c);
    c = 0;
    while (srst === 1'h1 && c < 100) begin
      @(posedge core_clk);
      c++;
    end
  endtask

  initial begin
    #400_000;
    fail_count++;
    finish_test();
  end

  //////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'h0;
    fuse_on = 1'h0;
    fuse_drop = 1'h0;
    sup_low = 1'h0;
    repeat (10) @(posedge core_clk);
    `CHK({irq, pulse, srst, ref_en}, 4'h0)
    arst_n <= 1'h1;
    foreach (rows[i]) begin
      core.xfer(rows[i].w, rows[i].a, rows[i].d);
      if (rows[i].w && rows[i].a == wdg_pkg::OFS_AUX) core.settle();
      if (!rows[i].w) `CHK(core.rd, rows[i].q)
      `CHK(core.err, rows[i].e)
      `CHK(ref_en, rows[i].r)
    end
    core.xfer(1'h1, C, 32'h08);
    rd(C, 32'h08);
    core.xfer(1'h1, C, 32'h01);
    rd(C, 32'h08);
    core.open_win();
    repeat (6) @(posedge core_clk);
    core.change(8'h00);
    rd(C, 32'h08);
    core.open_win();
    core.change(8'h00);
    rd(C, 32'h00);
    // Interrupt mode at two selects: 8 then 4 ticks
    for (int s = 1; s >= 0; s--) begin
      core.open_win();
      core.change(8'h40 | 8'(s));
      n = pulses;
      core.restart();
      wait_ev(1'h0, k);
      `CHK(k > (BASE << s) * T - T && k <= (BASE << s) * T + 8, 1'h1)
      `CHK(pulses, n)
      rd(C, 32'hc0 | s);
      core.ack_vec();
      repeat (2) @(posedge core_clk);
      `CHK(irq, 1'h0)
      rd(C, 32'h40 | s);
    end
    repeat (4) begin
      core.restart();
      repeat (3000) @(posedge core_clk);
    end
    `CHK(irq, 1'h0)
    core.open_win();
    core.change(8'h48);
    n = pulses;
    core.restart();
    wait_ev(1'h0, k);
    `CHK(pulses, n)
    core.ack_vec();
    rd(C, 32'h08);
    wait_ev(1'h1, k);
    @(posedge core_clk);
    `CHK(pulse, 1'h0)
    `CHK(srst, 1'h1)
    hold_len(k);
    `CHK(k >= DELAY - 2 && k <= DELAY + 5, 1'h1)
    rd(R, 32'h08);
    rd(C, 32'h08);
    core.open_win();
    core.change(8'h00);
    rd(C, 32'h08);
    core.init_clear();
    rd(C, 32'h00);
    fuse_drop <= 1'h1;
    repeat (4) @(posedge core_clk);
    `CHK(ref_en, 1'h1)
    sup_low <= 1'h1;
    repeat (300) @(posedge core_clk);
    sup_low <= 1'h0;
    repeat (100) @(posedge core_clk);
    `CHK(srst, 1'h0)
    sup_low <= 1'h1;
    repeat (395) @(posedge core_clk);
    `CHK(srst, 1'h0)
    repeat (15) @(posedge core_clk);
    `CHK(srst, 1'h1)
    sup_low <= 1'h0;
    hold_len(k);
    `CHK(k >= DELAY && k <= DELAY + 6, 1'h1)
    rd(R, 32'h04);
    core.xfer(1'h1, R, 32'h0);
    fuse_drop <= 1'h0;
    fuse_on <= 1'h1;
    repeat (4) @(posedge core_clk);
    core.xfer(1'h1, C, 32'h40);
    rd(C, 32'h08);
    core.restart();
    wait_ev(1'h1, k);
    `CHK(k > (BASE - 1) * T && k <= BASE * T + 8, 1'h1)
    `CHK(irq, 1'h0)
    arst_n <= 1'h0;
    repeat (3) @(posedge core_clk);
    `CHK({irq, pulse, srst, ref_en}, 4'h0)
    arst_n <= 1'h1;
    fuse_on <= 1'h0;
    repeat (3) @(posedge core_clk);
    rd(R, 32'h0);
    rd(C, 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire
